// ==== include/bmdl_pkg.sv ====
// Shared constants for the packed-BCD multiply, divide and long subtract unit.
// Assumes one 250 MHz clock and an instruction sequencer that supplies words.

package bmdl_pkg;

  // ==========================================================================
  // Widths
  localparam int WORD_W     = 16;
  localparam int OPD_DIGITS = 8;
  localparam int BIN_W      = 27;
  localparam int PROD_W     = 54;
  localparam int BCD_W      = 64;

  // ==========================================================================
  // Numeric constants
  localparam logic [26:0] TEN_POW8  = 27'h5F5E100;
  localparam logic [3:0]  DIGIT_MAX = 4'h9;
  localparam logic [3:0]  DAB_LIMIT = 4'h5;
  localparam logic [3:0]  DAB_ADD   = 4'h3;

  // ==========================================================================
  // Step counts
  localparam logic [5:0] TOBIN_LAST = 6'h07;
  localparam logic [5:0] DIV_LAST   = 6'h1A;
  localparam logic [5:0] DAB_SHORT  = 6'h1A;
  localparam logic [5:0] DAB_LONG   = 6'h35;

  // ==========================================================================
  // Operation select
  localparam logic [1:0] OP_LSUB = 2'h0;
  localparam logic [1:0] OP_PROD = 2'h1;
  localparam logic [1:0] OP_DIV  = 2'h2;

  // Result word counts
  localparam logic [2:0] CNT_TWO  = 3'h2;
  localparam logic [2:0] CNT_FOUR = 3'h4;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE   = 3'h0,
    S_CHECK  = 3'h1,
    S_TOBIN  = 3'h2,
    S_CALC   = 3'h3,
    S_DIVIDE = 3'h4,
    S_TOBCD  = 3'h5,
    S_WRITE  = 3'h6
  } bmdl_state_type;

endpackage : bmdl_pkg

// ==== design/bmdl_dabble_adj.sv ====
// Binary-to-BCD correction step: adds three to every digit of five or more.
// Purely combinational; the caller shifts after adjusting.
`timescale 1ns/1ps
`default_nettype none

module bmdl_dabble_adj (
  // Digits in
  input  wire logic [63:0] bcd_in,
  // Digits out
  output logic      [63:0] bcd_out
);

  // ==========================================================================
  // Per-digit adjust
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_dig
      always_comb begin
        if (bcd_in[gi*4 +: 4] >= bmdl_pkg::DAB_LIMIT) begin
          bcd_out[gi*4 +: 4] = bcd_in[gi*4 +: 4] + bmdl_pkg::DAB_ADD;
        end else begin
          bcd_out[gi*4 +: 4] = bcd_in[gi*4 +: 4];
        end
      end
    end
  endgenerate

endmodule : bmdl_dabble_adj
`default_nettype wire

// ==== design/bmdl_unit.sv ====
// Packed-BCD execution unit: long subtract, multiply and divide.
// Assumes operands are stable on the strobe cycle and busy is honoured.
`timescale 1ns/1ps
`default_nettype none

module bmdl_unit (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Instruction request
  input  wire logic        scan_strobe,
  input  wire logic        exec_cond,
  input  wire logic        diff_mode,
  input  wire logic [1:0]  op_sel,
  input  wire logic        op_wide,
  input  wire logic        carry_clr,
  // Operand words, low word first
  input  wire logic [15:0] src_a0,
  input  wire logic [15:0] src_a1,
  input  wire logic [15:0] src_b0,
  input  wire logic [15:0] src_b1,
  // Indirect pointer check
  input  wire logic        ind_used,
  input  wire logic [15:0] ind_ptr,
  input  wire logic [15:0] ind_area_last,
  // Handshake
  output logic             busy,
  output logic             done,
  // Result words
  output logic             res_we,
  output logic      [2:0]  res_cnt,
  output logic      [15:0] res_w0,
  output logic      [15:0] res_w1,
  output logic      [15:0] res_w2,
  output logic      [15:0] res_w3,
  // Flags
  output logic             carry_flag,
  output logic             fault_flag,
  output logic             zero_flag
);

  // ==========================================================================
  // State
  typedef struct packed {
    bmdl_pkg::bmdl_state_type st;
    logic [1:0]  op;
    logic        wide;
    logic        borrow_in;
    logic        ptr_bad;
    logic [5:0]  cnt;
    logic        pass;
    logic [31:0] a_bcd;
    logic [31:0] b_bcd;
    logic [26:0] a_bin;
    logic [26:0] b_bin;
    logic [26:0] rem;
    logic [53:0] val;
    logic [63:0] bcd;
    logic [31:0] q_bcd;
    logic        carry_p;
    logic        zero_p;
    logic        cond_prev;
    logic        busy;
    logic        done;
    logic        res_we;
    logic [2:0]  res_cnt;
    logic [15:0] w0;
    logic [15:0] w1;
    logic [15:0] w2;
    logic [15:0] w3;
    logic        carry;
    logic        fault;
    logic        zero;
  } bmdl_regs_type;

  bmdl_regs_type r;
  bmdl_regs_type n;

  logic [15:0] dig_ok;
  logic [63:0] src_all;
  logic [3:0]  ptr_dig_ok;
  logic        ptr_bad;
  logic        fire;
  logic        eff_wide;
  logic [53:0] prod;
  logic [63:0] adj;
  logic [27:0] trial;
  logic [27:0] tsub;
  logic [26:0] qn;
  logic [27:0] sub_rhs;
  logic [26:0] diff_pos;
  logic [26:0] diff_neg;
  logic [26:0] diff;
  logic        neg;
  logic [63:0] bcd_nx;
  logic [5:0]  dab_last;

  // ==========================================================================
  // Digit validity
  // Both operands, high digits first
  assign src_all = {r.b_bcd, r.a_bcd};
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_dok
      assign dig_ok[gi] = (src_all[gi*4 +: 4] <= bmdl_pkg::DIGIT_MAX);
    end
    for (gi = 0; gi < 4; gi++) begin : g_pok
      assign ptr_dig_ok[gi] = (ind_ptr[gi*4 +: 4] <= bmdl_pkg::DIGIT_MAX);
    end
  endgenerate

  // Pointer not decimal or past area end
  assign ptr_bad = ind_used && (!(&ptr_dig_ok) || (ind_ptr > ind_area_last));

  // Differentiated form needs a rising condition
  assign fire = exec_cond && (!diff_mode || !r.cond_prev) && (op_sel != 2'h3);

  // Long subtract always takes both words
  assign eff_wide = op_wide || (op_sel == bmdl_pkg::OP_LSUB);

  // ==========================================================================
  // Arithmetic
  assign prod     = {27'h0, r.a_bin} * {27'h0, r.b_bin};
  assign trial    = {r.rem, r.val[26]};
  assign tsub     = trial - {1'b0, r.b_bin};
  assign sub_rhs  = {1'b0, r.b_bin} + {27'h0, r.borrow_in};
  // Negative exactly when minuend below subtrahend plus carry
  assign neg      = ({1'b0, r.a_bin} < sub_rhs);
  assign diff_pos = r.a_bin - r.b_bin - {26'h0, r.borrow_in};
  // Ten's complement of a negative difference
  assign diff_neg = r.a_bin + bmdl_pkg::TEN_POW8 - r.b_bin - {26'h0, r.borrow_in};
  assign diff     = neg ? diff_neg : diff_pos;
  assign dab_last = (r.op == bmdl_pkg::OP_PROD && r.wide) ? bmdl_pkg::DAB_LONG
                                                         : bmdl_pkg::DAB_SHORT;
  assign bcd_nx   = {adj[62:0], r.val[53]};

  bmdl_dabble_adj u_adj (
    .bcd_in  (r.bcd),
    .bcd_out (adj)
  );

  // ==========================================================================
  // Next state
  always_comb begin
    n        = r;
    n.done   = 1'b0;
    n.res_we = 1'b0;
    qn       = {r.val[25:0], 1'b0};
    case (r.st)
      bmdl_pkg::S_IDLE: begin
        // Carry clear acts whenever idle
        if (carry_clr) begin
          n.carry = 1'b0;
        end
        if (scan_strobe) begin
          n.cond_prev = exec_cond;
          if (fire) begin
            n.op      = op_sel;
            n.wide    = eff_wide;
            n.borrow_in = carry_clr ? 1'b0 : r.carry;
            n.ptr_bad = ptr_bad;
            n.a_bcd   = {eff_wide ? src_a1 : 16'h0000, src_a0};
            n.b_bcd   = {eff_wide ? src_b1 : 16'h0000, src_b0};
            n.busy    = 1'b1;
            n.st      = bmdl_pkg::S_CHECK;
          end else begin
            // Skip straight to the next instruction
            n.done = 1'b1;
          end
        end
      end
      bmdl_pkg::S_CHECK: begin
        if (!(&dig_ok) || r.ptr_bad ||
            (r.op == bmdl_pkg::OP_DIV && r.b_bcd == 32'h00000000)) begin
          n.fault = 1'b1;
          n.done  = 1'b1;
          n.busy  = 1'b0;
          n.st    = bmdl_pkg::S_IDLE;
        end else begin
          n.cnt   = 6'h00;
          n.a_bin = 27'h0000000;
          n.b_bin = 27'h0000000;
          n.st    = bmdl_pkg::S_TOBIN;
        end
      end
      bmdl_pkg::S_TOBIN: begin
        // Accumulate one digit per cycle, most significant first
        n.a_bin = {r.a_bin[23:0], 3'h0} + {r.a_bin[25:0], 1'h0}
                  + {23'h000000, r.a_bcd[31:28]};
        n.b_bin = {r.b_bin[23:0], 3'h0} + {r.b_bin[25:0], 1'h0}
                  + {23'h000000, r.b_bcd[31:28]};
        n.a_bcd = {r.a_bcd[27:0], 4'h0};
        n.b_bcd = {r.b_bcd[27:0], 4'h0};
        n.cnt   = r.cnt + 6'h01;
        if (r.cnt == bmdl_pkg::TOBIN_LAST) begin
          n.st = bmdl_pkg::S_CALC;
        end
      end
      bmdl_pkg::S_CALC: begin
        n.cnt  = 6'h00;
        n.pass = 1'b0;
        n.bcd  = 64'h0000000000000000;
        n.st   = bmdl_pkg::S_TOBCD;
        case (r.op)
          bmdl_pkg::OP_LSUB: begin
            n.val     = {diff, 27'h0000000};
            n.carry_p = neg;
            n.zero_p  = (diff == 27'h0000000);
          end
          bmdl_pkg::OP_PROD: begin
            n.val     = r.wide ? prod : {prod[26:0], 27'h0000000};
            n.carry_p = !r.wide && (prod >= {27'h0, bmdl_pkg::TEN_POW8});
            n.zero_p  = (prod == 54'h0);
          end
          default: begin
            n.rem = 27'h0000000;
            n.val = {27'h0000000, r.a_bin};
            n.st  = bmdl_pkg::S_DIVIDE;
          end
        endcase
      end
      bmdl_pkg::S_DIVIDE: begin
        // Restoring division, one quotient bit per cycle
        if (!tsub[27]) begin
          n.rem = tsub[26:0];
          qn[0] = 1'b1;
        end else begin
          n.rem = trial[26:0];
        end
        n.val = {27'h0000000, qn};
        n.cnt = r.cnt + 6'h01;
        if (r.cnt == bmdl_pkg::DIV_LAST) begin
          n.val     = {qn, 27'h0000000};
          n.carry_p = r.carry;
          n.zero_p  = (qn == 27'h0000000);
          n.cnt     = 6'h00;
          n.pass    = 1'b0;
          n.bcd     = 64'h0000000000000000;
          n.st      = bmdl_pkg::S_TOBCD;
        end
      end
      bmdl_pkg::S_TOBCD: begin
        n.bcd = bcd_nx;
        n.val = {r.val[52:0], 1'b0};
        n.cnt = r.cnt + 6'h01;
        if (r.cnt == dab_last) begin
          if (r.op == bmdl_pkg::OP_DIV && !r.pass) begin
            // Quotient done, convert remainder next
            n.q_bcd = bcd_nx[31:0];
            n.val   = {r.rem, 27'h0000000};
            n.bcd   = 64'h0000000000000000;
            n.cnt   = 6'h00;
            n.pass  = 1'b1;
          end else begin
            n.st = bmdl_pkg::S_WRITE;
          end
        end
      end
      bmdl_pkg::S_WRITE: begin
        n.res_we = 1'b1;
        n.done   = 1'b1;
        n.busy   = 1'b0;
        n.fault  = 1'b0;
        n.carry  = r.carry_p;
        n.zero   = r.zero_p;
        n.st     = bmdl_pkg::S_IDLE;
        n.res_cnt = bmdl_pkg::CNT_TWO;
        // Low word at the lower address
        case (r.op)
          bmdl_pkg::OP_DIV: begin
            if (r.wide) begin
              n.w0      = r.q_bcd[15:0];
              n.w1      = r.q_bcd[31:16];
              n.w2      = r.bcd[15:0];
              n.w3      = r.bcd[31:16];
              n.res_cnt = bmdl_pkg::CNT_FOUR;
            end else begin
              n.w0 = r.q_bcd[15:0];
              n.w1 = r.bcd[15:0];
            end
          end
          default: begin
            n.w0 = r.bcd[15:0];
            n.w1 = r.bcd[31:16];
            if (r.op == bmdl_pkg::OP_PROD && r.wide) begin
              n.w2      = r.bcd[47:32];
              n.w3      = r.bcd[63:48];
              n.res_cnt = bmdl_pkg::CNT_FOUR;
            end
          end
        endcase
      end
      default: begin
        n.st   = bmdl_pkg::S_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ==========================================================================
  // Outputs
  assign busy       = r.busy;
  assign done       = r.done;
  assign res_we     = r.res_we;
  assign res_cnt    = r.res_cnt;
  assign res_w0     = r.w0;
  assign res_w1     = r.w1;
  assign res_w2     = r.w2;
  assign res_w3     = r.w3;
  assign carry_flag = r.carry;
  assign fault_flag = r.fault;
  assign zero_flag  = r.zero;

endmodule : bmdl_unit
`default_nettype wire

// ==== tb/bmdl_wmem.sv ====
// Word memory model: takes result words on each write pulse.
// Assumes result words are valid in the cycle of the write pulse.
`timescale 1ns/1ps
`default_nettype none

module bmdl_wmem (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Result write port
  input  wire logic        res_we,
  input  wire logic [2:0]  res_cnt,
  input  wire logic [15:0] res_w0,
  input  wire logic [15:0] res_w1,
  input  wire logic [15:0] res_w2,
  input  wire logic [15:0] res_w3,
  // Stored words, low address first
  output logic      [63:0] mem_all
);
  // ==========================================================================
  // Store
  // Consecutive words, low first
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_all <= 64'h0000000000000000;
    end else if (res_we) begin
      mem_all[31:0] <= {res_w1, res_w0};
      if (res_cnt == 3'h4) begin
        mem_all[63:32] <= {res_w3, res_w2};
      end
    end
  end
endmodule : bmdl_wmem

`default_nettype wire

// ==== tb/bmdl_chk.sv ====
// Port checker for the BCD execution unit.
// Assumes it is bound to bmdl_unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module bmdl_chk (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Request
  input  wire logic        scan_strobe,
  input  wire logic        exec_cond,
  input  wire logic        carry_clr,
  // Answer
  input  wire logic        busy,
  input  wire logic        done,
  input  wire logic        res_we,
  input  wire logic [15:0] res_w0,
  input  wire logic [15:0] res_w1,
  input  wire logic        carry_flag,
  input  wire logic        fault_flag,
  input  wire logic        zero_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // Sequences
  sequence s_accept;
    scan_strobe && !busy;
  endsequence
  sequence s_finish;
    ##[1:93] done;
  endsequence

  // ==========================================================================
  // Properties
  skip_quick_a: assert property (s_accept ##0 !exec_cond |=> done && !res_we)
    else $error("skipped op not finished in one cycle");
  op_finish_a: assert property (s_accept |-> s_finish)
    else $error("operation did not finish");
  write_ok_a: assert property (res_we |-> done && !fault_flag)
    else $error("write without clean done");
  words_hold_a: assert property (!res_we |-> $stable({res_w0, res_w1}))
    else $error("result words changed without write");
  flags_hold_a: assert property (!done |-> $stable({fault_flag, zero_flag}))
    else $error("flags changed outside done");
  carry_hold_a: assert property (!done && !$past(carry_clr) |-> $stable(carry_flag))
    else $error("carry changed outside done");
  carry_clr_a: assert property (carry_clr && !busy |=> !carry_flag)
    else $error("carry not cleared");
  busy_end_a: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
  zero_word_a: assert property (res_we && zero_flag |-> res_w0 == 16'h0000)
    else $error("zero flag with nonzero low word");
endmodule : bmdl_chk

`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench: corner and random BCD operations.
// Assumes bmdl_unit, bmdl_chk and bmdl_wmem are compiled first.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [1:0] OPC_DIFF = 2'h0;
  localparam logic [1:0] OPC_PROD = 2'h1;
  localparam logic [1:0] OPC_QUOT = 2'h2;
  logic        mclk, rst, scan_strobe, exec_cond, diff_mode, op_wide, carry_clr;
  logic        ind_used, busy, done, res_we, carry_flag, fault_flag, zero_flag;
  logic [1:0]  op_sel;
  logic [2:0]  res_cnt;
  logic [15:0] src_a0, src_a1, src_b0, src_b1, ind_ptr, ind_area_last;
  logic [15:0] res_w0, res_w1, res_w2, res_w3;
  logic [63:0] mem_all, ewv;
  logic        ecarry, efl, ezr, cprev;
  int          err_total, samples_checked, seed, i;

  bmdl_unit dut_u (.*);
  bmdl_wmem wmem_u (.*);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // ==========================================================================
  // Helpers
  function automatic longint b2i(input logic [63:0] x);
    b2i = 0;
    for (int k = 15; k >= 0; k--) b2i = b2i * 10 + x[4*k +: 4];
  endfunction : b2i
  function automatic logic [63:0] i2b(input longint v);
    for (int k = 0; k < 16; k++) begin
      i2b[4*k +: 4] = 4'(v % 10);
      v = v / 10;
    end
  endfunction : i2b
  function automatic logic okb(input logic [31:0] x);
    okb = 1'b1;
    for (int k = 0; k < 8; k++) if (x[4*k +: 4] > 4'h9) okb = 1'b0;
  endfunction : okb
  function automatic logic [31:0] rnd();
    rnd = 32'(i2b(longint'({$random(seed)} % 100000000)));
  endfunction : rnd

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic go(input logic [1:0] o, input logic w, input logic [31:0] a, b,
                    input logic cnd, dif, clr, badp);
    longint      av, bv, sv;
    logic [31:0] am, bm;
    logic [63:0] r;
    logic        ex, flt, wes;
    int          lat, k;
    ex = cnd && (o != 2'h3) && !(dif && cprev);
    cprev = cnd;
    if (clr) ecarry = 1'b0;
    am = (w || o == OPC_DIFF) ? a : {16'h0000, a[15:0]};
    bm = (w || o == OPC_DIFF) ? b : {16'h0000, b[15:0]};
    av = b2i({32'h0, am});
    bv = b2i({32'h0, bm});
    flt = badp || !okb(am) || !okb(bm) || (o == OPC_QUOT && bv == 0);
    lat = !ex ? 1 : flt ? 2 : o == OPC_QUOT ? 93 : (o == OPC_PROD && w) ? 66 : 39;
    k = (o == OPC_DIFF || !w) ? 2 : 4;
    if (ex && !flt) begin
      case (o)
        OPC_DIFF: begin
          sv = av - bv - ecarry;
          ecarry = sv < 0;
          if (sv < 0) sv += 100000000;
          r = i2b(sv);
        end
        OPC_PROD: begin
          sv = av * bv;
          ecarry = 1'b0;
          r = i2b(sv);
        end
        default: begin
          sv = av / bv;
          r = (i2b(av % bv) << (w ? 32 : 16)) | i2b(sv);
        end
      endcase
      ezr = sv == 0;
      ewv[31:0] = r[31:0];
      if (k == 4) ewv[63:32] = r[63:32];
    end
    if (ex) efl = flt;
    @(negedge mclk);
    {op_sel, op_wide, exec_cond, diff_mode, carry_clr} = {o, w, cnd, dif, clr};
    {src_a1, src_a0, src_b1, src_b0} = {a, b};
    ind_ptr = badp ? 16'h1000 : 16'h0042;
    scan_strobe = 1'b1;
    @(negedge mclk);
    scan_strobe = 1'b0;
    carry_clr = 1'b0;
    for (k = 1; k < 200 && done !== 1'b1; k++) @(negedge mclk);
    wes = res_we;
    chk("latency", 64'(k), 64'(lat));
    chk("write", 64'(wes), 64'(ex && !flt));
    chk("words", {res_w3, res_w2, res_w1, res_w0}, ewv);
    chk("flags", {carry_flag, fault_flag, zero_flag}, {ecarry, efl, ezr});
    // Memory takes the words at the edge after the write pulse
    @(negedge mclk);
    chk("memory", mem_all, ewv);
  endtask : go

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  initial begin
    #100000;
    err_total++;
    close_out();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {scan_strobe, exec_cond, diff_mode, op_sel, op_wide, carry_clr} = '0;
    {src_a0, src_a1, src_b0, src_b1, ind_ptr} = '0;
    {ewv, ecarry, efl, ezr, cprev, err_total, samples_checked} = '0;
    ind_used = 1'b1;
    ind_area_last = 16'h0999;
    seed = 12;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    go(OPC_DIFF, 1'b0, 32'h00001029, 32'h00003452, 1'b1, 1'b0, 1'b1, 1'b0);
    go(OPC_DIFF, 1'b0, 32'h00000000, 32'h99997577, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_DIFF, 1'b0, 32'h12345678, 32'h12345678, 1'b1, 1'b0, 1'b1, 1'b0);
    go(OPC_PROD, 1'b0, 32'h00000335, 32'h00000025, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_PROD, 1'b1, 32'h99999999, 32'h99999999, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_QUOT, 1'b0, 32'h00003452, 32'h00000100, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_QUOT, 1'b1, 32'h87654321, 32'h00012345, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_DIFF, 1'b0, 32'hA0000000, 32'h00000001, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_PROD, 1'b0, 32'h0000A123, 32'h00000002, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_PROD, 1'b1, 32'h1B000000, 32'h00000002, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_QUOT, 1'b0, 32'h0000001F, 32'h00000003, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_QUOT, 1'b1, 32'h00000050, 32'h00000000, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_QUOT, 1'b1, 32'h00000050, 32'h0000C000, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_DIFF, 1'b0, 32'h00000009, 32'h00000001, 1'b1, 1'b0, 1'b0, 1'b1);
    go(OPC_QUOT, 1'b0, 32'h00000009, 32'h00000001, 1'b0, 1'b0, 1'b0, 1'b0);
    go(2'h3, 1'b0, 32'h00000009, 32'h00000001, 1'b1, 1'b0, 1'b0, 1'b0);
    go(OPC_PROD, 1'b0, 32'h00000007, 32'h00000003, 1'b1, 1'b1, 1'b0, 1'b0);
    go(OPC_DIFF, 1'b0, 32'h00000000, 32'h00000000, 1'b0, 1'b1, 1'b0, 1'b0);
    go(OPC_PROD, 1'b0, 32'h00000006, 32'h00000003, 1'b1, 1'b1, 1'b0, 1'b0);
    for (i = 0; i < 60; i++) begin
      go(2'({$random(seed)} % 3), 1'($random(seed)), rnd(), rnd(), ($random(seed) & 7) != 0,
         1'($random(seed)), 1'($random(seed)), ($random(seed) & 15) == 0);
    end
    close_out();
  end
endmodule : tb_top

bind bmdl_unit bmdl_chk chk_u (
  .mclk        (mclk),
  .rst         (rst),
  .scan_strobe (scan_strobe),
  .exec_cond   (exec_cond),
  .carry_clr   (carry_clr),
  .busy        (busy),
  .done        (done),
  .res_we      (res_we),
  .res_w0      (res_w0),
  .res_w1      (res_w1),
  .carry_flag  (carry_flag),
  .fault_flag  (fault_flag),
  .zero_flag   (zero_flag)
);

`default_nettype wire
